// ==== logic/rtcc_pkg.sv ====
// Purpose: shared constants and carriers for the room temperature controller
// Assumes: temperatures in signed hundredths of a degree Celsius
// Notes: register indices are word addresses on the plain register port
package rtcc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int VAL_W = 7;
  localparam int TEMP_W = 18;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_HEAT_SP = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DEAD_ZONE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_HEAT_HYST = 4'h3;
  localparam logic [ADDR_W-1:0] REG_COOL_HYST = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ADD_SP = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ADD_HYST = 4'h6;
  localparam logic [ADDR_W-1:0] REG_BAND = 4'h7;
  localparam logic [ADDR_W-1:0] REG_INT_TIME = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STAT_ON = 4'h9;
  localparam logic [ADDR_W-1:0] REG_VAL_HEAT = 4'ha;
  localparam logic [ADDR_W-1:0] REG_VAL_COOL = 4'hb;
  localparam logic [ADDR_W-1:0] REG_VAL_ADD = 4'hc;
  localparam logic [ADDR_W-1:0] REG_TEMP = 4'hd;
  localparam logic [ADDR_W-1:0] REG_COOL_SP = 4'he;
  localparam logic [5:0] CTRL_RST = 6'h02;
  localparam logic [15:0] HEAT_SP_RST = 16'h0834;
  localparam logic [15:0] DEAD_ZONE_RST = 16'h0190;
  localparam logic [15:0] HYST_RST = 16'h0064;
  localparam logic [15:0] ADD_SP_RST = 16'h07d0;
  localparam logic [15:0] BAND_RST = 16'h00c8;
  localparam logic [15:0] INT_TIME_RST = 16'h003c;

  typedef struct packed {
    logic add_en;
    logic add_2pt;
    logic cool_pi;
    logic cool_2pt;
    logic heat_pi;
    logic heat_2pt;
  } rtcc_ctrl_type;

  typedef struct packed {
    logic [VAL_W-1:0] heat_val;
    logic [VAL_W-1:0] cool_val;
    logic [VAL_W-1:0] add_val;
    logic heat_on;
    logic cool_on;
    logic add_on;
  } rtcc_act_type;
endpackage : rtcc_pkg

// ==== logic/rtcc_core.sv ====
// Purpose: heating, cooling and additional stage controller core
// Assumes: temp_valid_in marks an accepted sample, inputs synchronous to clk_sys_in
// Notes: all stages are re-evaluated only on accepted samples
// Functional notes
// - p law: value equals deviation times 100 divided by bandwidth
// - deviation beyond bandwidth drives full 100 percent
// - pi output at first deviation equals p law output
// - pi keeps raising value while setpoint unreached, rate from integration time
// - pi holds its value once temperature equals setpoint
// - two-point stages give on/off, continuous stages 0 to 100 percent
// - heat 2pt/pi positive hyst, cool 2pt/pi negative, add 2pt/p negative
// - negative hyst heating: on until setpoint, on again below setpoint minus hyst
// - negative hyst cooling: on until setpoint minus hyst, on again above setpoint
// - positive hyst heating: on until setpoint plus hyst, on again below setpoint
// - inside dead zone neither heating nor cooling is commanded
// - cooling setpoint adds dead zone plus hysteresis of the heating and cooling two-point stages
// - continuous heating and cooling stages selectable as p or pi
`timescale 1ns/1ns

module rtcc_loop #(
  parameter int VAL_W = 7,
  parameter int DEV_W = 18
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic smp_in,
  input wire logic signed [DEV_W-1:0] dev_in,
  input wire logic [15:0] band_in,
  input wire logic [15:0] int_time_in,
  input wire logic pi_in,
  input wire logic force_off_in,
  output logic [VAL_W-1:0] value_out
);
  import rtcc_pkg::*;
  logic signed [31:0] acc_reg;
  logic signed [31:0] acc_next;
  logic signed [31:0] band_s;
  logic signed [31:0] ti_s;
  logic signed [31:0] p_full;
  logic signed [31:0] p_lim;
  logic signed [31:0] i_term;
  logic signed [31:0] sum;
  logic signed [31:0] acc_max;
  logic signed [31:0] full_s;
  logic [VAL_W-1:0] val_next;

  always_comb begin
    full_s = $signed({25'h0000000, PCT_FULL});
    // zero settings are treated as one to keep the divider defined
    band_s = (band_in == 16'h0000) ? 32'sh1 : $signed({16'h0000, band_in});
    ti_s = (int_time_in == 16'h0000) ? 32'sh1 : $signed({16'h0000, int_time_in});
    p_full = (32'(dev_in) * full_s) / band_s;
    if (p_full > full_s) begin
      p_lim = full_s;
    end else if (p_full < -full_s) begin
      p_lim = -full_s;
    end else begin
      p_lim = p_full;
    end
    i_term = pi_in ? (acc_reg / ti_s) : 32'sh0;
    sum = p_lim + i_term;
    if (sum > full_s) begin
      val_next = PCT_FULL;
    end else if (sum < 32'sh0) begin
      val_next = '0;
    end else begin
      val_next = sum[VAL_W-1:0];
    end
    // integral bounded so that it alone can just reach full scale
    acc_max = ti_s * full_s;
    acc_next = acc_reg + p_lim;
    if (acc_next > acc_max) begin
      acc_next = acc_max;
    end else if (acc_next < 32'sh0) begin
      acc_next = 32'sh0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acc_reg <= 32'sh0;
      value_out <= '0;
    end else if (ce_in && smp_in) begin
      if (force_off_in) begin
        acc_reg <= 32'sh0;
        value_out <= '0;
      end else if (pi_in && dev_in == '0) begin
        value_out <= value_out;
      end else begin
        value_out <= val_next;
        acc_reg <= pi_in ? acc_next : 32'sh0;
      end
    end
  end
endmodule : rtcc_loop

module rtcc_core (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic temp_valid_in,
  input wire logic signed [15:0] temp_in,
  input wire logic [rtcc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [rtcc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [rtcc_pkg::DATA_W-1:0] reg_rdata_out,
  output rtcc_pkg::rtcc_act_type act_out
);
  import rtcc_pkg::*;
  rtcc_ctrl_type ctrl_reg;
  logic signed [15:0] heat_sp_reg;
  logic signed [15:0] add_sp_reg;
  logic [15:0] dead_zone_reg, heat_hyst_reg, cool_hyst_reg, add_hyst_reg, band_reg, int_time_reg;
  logic signed [15:0] temp_reg;
  logic heat_on_reg, cool_on_reg, add_on_reg;
  logic smp;
  logic signed [TEMP_W-1:0] t_x, heat_sp_x, add_sp_x, cool_sp;
  logic signed [TEMP_W-1:0] heat_dev, cool_dev, add_dev;
  logic [VAL_W-1:0] heat_val, cool_val, add_val;

  assign smp = ce_in && temp_valid_in;

  always_comb begin
    t_x = TEMP_W'(temp_in);
    heat_sp_x = TEMP_W'(heat_sp_reg);
    add_sp_x = TEMP_W'(add_sp_reg);
    // two-point switching bands widen the gap so stages never overlap
    cool_sp = heat_sp_x + $signed({2'b00, dead_zone_reg})
      + (ctrl_reg.heat_2pt ? $signed({2'b00, heat_hyst_reg}) : '0)
      + (ctrl_reg.cool_2pt ? $signed({2'b00, cool_hyst_reg}) : '0);
    heat_dev = heat_sp_x - t_x;
    cool_dev = t_x - cool_sp;
    add_dev = add_sp_x - t_x;
  end

  // register writes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= CTRL_RST;
      heat_sp_reg <= HEAT_SP_RST;
      dead_zone_reg <= DEAD_ZONE_RST;
      heat_hyst_reg <= HYST_RST;
      cool_hyst_reg <= HYST_RST;
      add_sp_reg <= ADD_SP_RST;
      add_hyst_reg <= HYST_RST;
      band_reg <= BAND_RST;
      int_time_reg <= INT_TIME_RST;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        REG_CTRL: ctrl_reg <= reg_wdata_in[5:0];
        REG_HEAT_SP: heat_sp_reg <= reg_wdata_in;
        REG_DEAD_ZONE: dead_zone_reg <= reg_wdata_in;
        REG_HEAT_HYST: heat_hyst_reg <= reg_wdata_in;
        REG_COOL_HYST: cool_hyst_reg <= reg_wdata_in;
        REG_ADD_SP: add_sp_reg <= reg_wdata_in;
        REG_ADD_HYST: add_hyst_reg <= reg_wdata_in;
        REG_BAND: band_reg <= reg_wdata_in;
        REG_INT_TIME: int_time_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // read data valid only the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (ce_in) begin
      if (!reg_rd_in) begin
        reg_rdata_out <= '0;
      end else begin
        case (reg_addr_in)
          REG_CTRL: reg_rdata_out <= {10'h000, ctrl_reg};
          REG_HEAT_SP: reg_rdata_out <= heat_sp_reg;
          REG_DEAD_ZONE: reg_rdata_out <= dead_zone_reg;
          REG_HEAT_HYST: reg_rdata_out <= heat_hyst_reg;
          REG_COOL_HYST: reg_rdata_out <= cool_hyst_reg;
          REG_ADD_SP: reg_rdata_out <= add_sp_reg;
          REG_ADD_HYST: reg_rdata_out <= add_hyst_reg;
          REG_BAND: reg_rdata_out <= band_reg;
          REG_INT_TIME: reg_rdata_out <= int_time_reg;
          REG_STAT_ON: reg_rdata_out <= {13'h0000, heat_on_reg, cool_on_reg, add_on_reg};
          REG_VAL_HEAT: reg_rdata_out <= {9'h000, heat_val};
          REG_VAL_COOL: reg_rdata_out <= {9'h000, cool_val};
          REG_VAL_ADD: reg_rdata_out <= {9'h000, add_val};
          REG_TEMP: reg_rdata_out <= temp_reg;
          REG_COOL_SP: reg_rdata_out <= cool_sp[15:0];
          default: reg_rdata_out <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      temp_reg <= '0;
    end else if (smp) begin
      temp_reg <= temp_in;
    end
  end

  // two-point stages
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      heat_on_reg <= 1'b0;
      cool_on_reg <= 1'b0;
      add_on_reg <= 1'b0;
    end else if (smp) begin
      if (!ctrl_reg.heat_2pt) begin
        heat_on_reg <= 1'b0;
      end else if (t_x < heat_sp_x) begin
        heat_on_reg <= 1'b1;
      end else if (t_x >= heat_sp_x + $signed({2'b00, heat_hyst_reg})) begin
        heat_on_reg <= 1'b0;
      end
      if (!ctrl_reg.cool_2pt) begin
        cool_on_reg <= 1'b0;
      end else if (t_x > cool_sp) begin
        cool_on_reg <= 1'b1;
      end else if (t_x <= cool_sp - $signed({2'b00, cool_hyst_reg})) begin
        cool_on_reg <= 1'b0;
      end
      if (!ctrl_reg.add_en || !ctrl_reg.add_2pt) begin
        add_on_reg <= 1'b0;
      end else if (t_x >= add_sp_x) begin
        add_on_reg <= 1'b0;
      end else if (t_x < add_sp_x - $signed({2'b00, add_hyst_reg})) begin
        add_on_reg <= 1'b1;
      end
    end
  end

  // continuous stages; additional stage has no integral part
  rtcc_loop #(.VAL_W(VAL_W), .DEV_W(TEMP_W)) u_heat (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .smp_in(temp_valid_in),
    .dev_in(heat_dev),
    .band_in(band_reg),
    .int_time_in(int_time_reg),
    .pi_in(ctrl_reg.heat_pi),
    .force_off_in(ctrl_reg.heat_2pt || heat_dev < 0),
    .value_out(heat_val)
  );
  rtcc_loop #(.VAL_W(VAL_W), .DEV_W(TEMP_W)) u_cool (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .smp_in(temp_valid_in),
    .dev_in(cool_dev),
    .band_in(band_reg),
    .int_time_in(int_time_reg),
    .pi_in(ctrl_reg.cool_pi),
    .force_off_in(ctrl_reg.cool_2pt || cool_dev < 0),
    .value_out(cool_val)
  );
  rtcc_loop #(.VAL_W(VAL_W), .DEV_W(TEMP_W)) u_add (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .smp_in(temp_valid_in),
    .dev_in(add_dev),
    .band_in(band_reg),
    .int_time_in(int_time_reg),
    .pi_in(1'b0),
    .force_off_in(!ctrl_reg.add_en || ctrl_reg.add_2pt || add_dev < 0),
    .value_out(add_val)
  );

  assign act_out = '{heat_val, cool_val, add_val, heat_on_reg, cool_on_reg, add_on_reg};

  property p_val_range;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      heat_val <= PCT_FULL && cool_val <= PCT_FULL && add_val <= PCT_FULL;
  endproperty
  a_val_range: assert property (p_val_range) else $error("value above full scale");

  property p_heat_on;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.heat_2pt && t_x < heat_sp_x |=> act_out.heat_on;
  endproperty
  a_heat_on: assert property (p_heat_on) else $error("heating not on below setpoint");

  property p_heat_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.heat_2pt && t_x >= heat_sp_x + $signed({2'b00, heat_hyst_reg}) |=> !act_out.heat_on;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heating on above band");

  property p_cool_on;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.cool_2pt && t_x > cool_sp |=> act_out.cool_on;
  endproperty
  a_cool_on: assert property (p_cool_on) else $error("cooling not on above setpoint");

  property p_cool_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.cool_2pt && t_x <= cool_sp - $signed({2'b00, cool_hyst_reg}) |=> !act_out.cool_on;
  endproperty
  a_cool_off: assert property (p_cool_off) else $error("cooling on below band");

  property p_add_band;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.add_en && ctrl_reg.add_2pt && t_x < add_sp_x
        && t_x >= add_sp_x - $signed({2'b00, add_hyst_reg}) |=> $stable(act_out.add_on);
  endproperty
  a_add_band: assert property (p_add_band) else $error("additional stage changed inside band");

  property p_add_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && t_x >= add_sp_x |=> !act_out.add_on && act_out.add_val == '0;
  endproperty
  a_add_off: assert property (p_add_off) else $error("additional stage on at setpoint");

  property p_dead_zone;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && t_x > heat_sp_x && t_x < cool_sp |=> act_out.heat_val == '0 && act_out.cool_val == '0;
  endproperty
  a_dead_zone: assert property (p_dead_zone) else $error("continuous output in dead zone");

  property p_full_band;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && !ctrl_reg.heat_2pt && heat_dev >= $signed({2'b00, band_reg}) |=> act_out.heat_val == PCT_FULL;
  endproperty
  a_full_band: assert property (p_full_band) else $error("heating not full beyond band");

  property p_pi_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      smp && ctrl_reg.heat_pi && !ctrl_reg.heat_2pt && heat_dev == '0 |=> $stable(act_out.heat_val);
  endproperty
  a_pi_hold: assert property (p_pi_hold) else $error("pi value moved at setpoint");
endmodule : rtcc_core

// ==== verification/rtcc_room_model.sv ====
// Purpose: room temperature source feeding samples into the controller core
// Assumes: one request pulse gives one sample strobe on the next cycle
// Notes: between samples the value line is inverted, as a released source would show
`timescale 1ns/1ns
module rtcc_room_model (
  input wire logic clk_sys_in,
  input wire logic req_in,
  input wire logic signed [15:0] temp_req_in,
  output logic temp_valid_out,
  output logic signed [15:0] temp_out
);
  initial begin
    temp_valid_out = 1'b0;
    temp_out = 16'sh0000;
  end
  // stale values must never look like a fresh sample
  always @(posedge clk_sys_in) begin
    temp_valid_out <= req_in;
    temp_out <= req_in ? temp_req_in : ~temp_out;
  end
endmodule : rtcc_room_model

// ==== verification/rtcc_core_test.sv ====
// Purpose: self-checking bench for the room temperature controller core
// Assumes: one sample every four cycles, register strobes with one idle cycle
// Notes: expectations queued by drivers, compared by a separate monitor
`timescale 1ns/1ns
module rtcc_core_test;
  import rtcc_pkg::*;
  typedef struct packed {
    logic [23:0] m;
    logic [23:0] v;
  } rtcc_exp_type;
  localparam logic [23:0] M_HV = 24'hfe0000;
  localparam logic [23:0] M_CV = 24'h01fc00;
  localparam logic [23:0] M_AV = 24'h0003f8;
  localparam logic [23:0] M_HO = 24'h000004;
  localparam logic [23:0] M_CO = 24'h000002;
  localparam logic [23:0] M_AO = 24'h000001;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic req = 1'b0;
  logic signed [15:0] treq = 16'sh0000;
  logic temp_valid;
  logic signed [15:0] temp;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  rtcc_act_type act;
  rtcc_exp_type act_q[$];
  rtcc_exp_type e;
  logic [15:0] rd_q[$];
  logic act_pend = 1'b0;
  logic rd_pend = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int acc;
  int r;
  logic [15:0] dflt [0:8] = '{CTRL_RST, HEAT_SP_RST, DEAD_ZONE_RST, HYST_RST, HYST_RST, ADD_SP_RST, HYST_RST,
                              BAND_RST, INT_TIME_RST};

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  rtcc_room_model room (.clk_sys_in(clk_sys_in), .req_in(req), .temp_req_in(treq), .temp_valid_out(temp_valid),
    .temp_out(temp));
  rtcc_core uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .temp_valid_in(temp_valid),
    .temp_in(temp), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .act_out(act));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wreg

  task automatic rreg(input logic [3:0] a, input logic [15:0] d);
    rd_q.push_back(d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
  endtask : rreg

  // x lands in the lowest field of the mask, other masked fields expected zero
  task automatic smp(input int t, input logic [23:0] m, input int x);
    logic [23:0] lsb;
    lsb = m & (~m + 24'h000001);
    act_q.push_back({m, (24'(x) * lsb) & m});
    treq <= 16'(t);
    req <= 1'b1;
    @(posedge clk_sys_in);
    req <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : smp

  // on, hold on, off at threshold, hold off, on again
  task automatic tpt(input logic [15:0] c, input logic [23:0] m, input int t[5]);
    int on[5] = '{1, 1, 0, 0, 1};
    wreg(REG_CTRL, c);
    foreach (t[k]) smp(t[k], m, on[k]);
  endtask : tpt

  // results appear at the accepting edge and are looked at one cycle later
  always @(posedge clk_sys_in) begin
    if (act_pend) begin
      e = act_q.pop_front();
      chk(act & e.m, e.v);
    end
    if (rd_pend) begin
      chk({8'h00, rdata}, {8'h00, rd_q.pop_front()});
    end
    act_pend <= rst_n_in && ce_in && temp_valid;
    rd_pend <= rst_n_in && ce_in && rd;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    close_out();
  end

  initial begin
    r = $urandom(58502);
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 9; i++) rreg(4'(i), dflt[i]);
    rreg(4'hf, 16'h0000);
    rreg(REG_STAT_ON, 16'h0000);
    rreg(REG_COOL_SP, 16'h09c4);
    wreg(REG_CTRL, 16'h0000);
    smp(1900, M_HV, 100);
    smp(1899, M_HV, 100);
    for (int i = 0; i < 8; i++) begin
      r = $urandom_range(0, 400);
      smp(2500 + r, M_HV | M_CV, (r / 2 > 100) ? 100 : r / 2);
    end
    smp(2300, M_HV | M_CV | M_HO | M_CO, 0);
    smp(2600, M_CV, 50);
    wreg(REG_BAND, 16'h0190);
    smp(2000, M_HV, 25);
    wreg(REG_BAND, 16'h00c8);
    wreg(REG_CTRL, 16'h0002);
    wreg(REG_INT_TIME, 16'h0004);
    smp(2200, M_HV, 0);
    acc = 0;
    for (int i = 0; i < 4; i++) begin
      smp(2000, M_HV, (50 + acc / 4 > 100) ? 100 : 50 + acc / 4);
      acc = (acc + 50 > 400) ? 400 : acc + 50;
    end
    smp(2100, M_HV, 87);
    smp(2100, M_HV, 87);
    // a frozen core must ignore the sample; a later write to the read-only heat value is dropped
    ce_in <= 1'b0;
    treq <= 16'sd1800;
    req <= 1'b1;
    @(posedge clk_sys_in);
    req <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ce_in <= 1'b1;
    wreg(REG_VAL_HEAT, 16'h0005);
    rreg(REG_VAL_HEAT, 16'h0057);
    // cooling integral path, same integration time as heating
    wreg(REG_CTRL, 16'h000a);
    smp(2550, M_HV | M_CV, 25);
    smp(2550, M_HV | M_CV, 31);
    smp(2500, M_HV | M_CV, 31);
    rreg(REG_VAL_COOL, 16'h001f);
    wreg(REG_CTRL, 16'h0001);
    rreg(REG_COOL_SP, 16'h0a28);
    tpt(16'h0001, M_HO | M_HV, '{1900, 2150, 2200, 2150, 2099});
    tpt(16'h0005, M_CO | M_CV, '{2750, 2650, 2600, 2690, 2701});
    rreg(REG_COOL_SP, 16'h0a8c);
    tpt(16'h0030, M_AO | M_AV, '{1850, 1950, 2000, 1950, 1899});
    rreg(REG_STAT_ON, 16'h0001);
    wreg(REG_CTRL, 16'h0020);
    smp(1900, M_AV, 50);
    rreg(REG_VAL_ADD, 16'h0032);
    rreg(REG_TEMP, 16'h076c);
    repeat (4) @(posedge clk_sys_in);
    if (act_q.size() != 0 || rd_q.size() != 0) begin
      miscompares++;
    end
    close_out();
  end
endmodule : rtcc_core_test
